// file: inc/spec_pkg.sv
// Shared constants and types for the splitter port enable control block
package spec_pkg;

  // ******************************************************
  // Register indexes (byte address = index * 4)
  // ******************************************************
  localparam logic [2:0] CFG_IDX    = 3'h0;
  localparam logic [2:0] RXSET_IDX  = 3'h1;
  localparam logic [2:0] STAT_IDX   = 3'h2;
  localparam logic [2:0] MASK_IDX   = 3'h3;
  localparam logic [2:0] PINS_IDX   = 3'h4;
  localparam int         ADDR_LSB   = 2;

  // ******************************************************
  // Reset values and field positions
  // ******************************************************
  localparam logic [7:0] CFG_RST     = 8'hff;
  localparam logic [7:0] RXSET_RST   = 8'h00;
  localparam logic [2:0] MASK_RST    = 3'h0;
  localparam int         CFG_NORMAL  = 7;
  localparam int         CFG_PORT_A  = 5;
  localparam int         CFG_PORT_B  = 4;
  localparam int         RX_TERM_OFF = 7;
  localparam int         RX_SQ_OFF   = 1;

  // Interrupt status bits
  localparam int EV_SQ_ENTER = 0;
  localparam int EV_SQ_LEAVE = 1;
  localparam int EV_HP_CHG   = 2;
  localparam int EV_NUM      = 3;

  // ******************************************************
  // Clock-detect glitch filter timing
  // ******************************************************
  localparam int CLK_HZ       = 200_000_000;
  localparam int FILT_NS      = 100;
  localparam int FILT_CYCLES  = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FILT_W       = $clog2(FILT_CYCLES + 1);

  // Pre-emphasis setting, code order 0, 1.5, 2.5, 3.5 dB
  typedef enum logic [1:0] {
    EMPH_0DB0 = 2'h0,
    EMPH_1DB5 = 2'h1,
    EMPH_2DB5 = 2'h2,
    EMPH_3DB5 = 2'h3
  } spec_emph_type;

  // Squelch state, filtered clock-detect driven
  typedef enum logic {
    SQ_RUN  = 1'b0,
    SQ_MUTE = 1'b1
  } spec_sq_type;

  // Strap pins sampled by the block
  typedef struct packed {
    logic output_gate;
    logic control_mode_strap;
    logic broadcast_select;
    logic port_selector;
    logic preemph_code_hi;
    logic preemph_code_lo;
    logic swing_code_hi;
    logic swing_code_lo;
  } spec_strap_type;

  // Per-port analog controls
  typedef struct packed {
    logic enable;
    logic drv_hiz;
  } spec_port_type;

endpackage

// file: rtl/spec_ctrl.sv
// Port enable, hot-plug, squelch and register logic of the 1:2 link splitter
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/10ps

module spec_ctrl #(
  parameter int ADDR_W = 5
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]     avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output logic                       irq_o,
  // Straps and sink side
  input  wire spec_pkg::spec_strap_type strap_i,
  input  wire logic                  hotplug_port_a_i,
  input  wire logic                  hotplug_port_b_i,
  input  wire logic                  link_clk_level_i,
  input  wire logic                  rout_select_i,
  // Analog controls
  output spec_pkg::spec_port_type    port_a_o,
  output spec_pkg::spec_port_type    port_b_o,
  output logic                       hotplug_to_source_o,
  output logic                       port_status_o,
  output logic                       rx_on_o,
  output logic                       input_term_res_en_o,
  output logic                       src_term_en_o,
  output spec_pkg::spec_emph_type    preemph_o,
  output logic [1:0]                 swing_code_o,
  output logic [3:0]                 bus_addr_o,
  output logic                       squelched_o
);

  // ******************************************************
  // Declarations
  // ******************************************************

  // Operating mode as the straps decode it
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_BCAST  = 2'h3,
    MODE_REG    = 2'h2
  } spec_mode_type;

  // Register bus and register file
  logic [7:0]                      cfg_q;
  logic [7:0]                      rxset_q;
  logic [spec_pkg::EV_NUM-1:0]     stat_q;
  logic [spec_pkg::EV_NUM-1:0]     mask_q;
  logic [spec_pkg::EV_NUM-1:0]     events;
  logic                            ack_q;
  logic [31:0]                     rdata_q;
  logic [31:0]                     rd_value;
  logic [2:0]                      reg_idx;
  logic                            reg_hit;
  logic                            wr_done;
  logic                            rd_done;

  // Clock-detect filter and event history
  logic                            det_q;
  logic [spec_pkg::FILT_W-1:0]     filt_cnt_q;
  spec_pkg::spec_sq_type           sq_state;
  spec_pkg::spec_sq_type           sq_prev_q;
  logic                            hp_out_prev_q;

  // Port decision
  logic                            gate;
  logic                            reg_mode;
  logic                            sq_enabled;
  spec_mode_type                   mode;
  logic                            sel_a;
  logic                            sel_b;
  logic                            hp_out;
  logic [1:0]                      sel_vec;
  logic [1:0]                      hp_vec;
  logic [1:0]                      en_vec;

  // Register index from a byte address; the two low bits and any bits above the index are ignored
  function automatic logic [2:0] word_idx(input logic [ADDR_W-1:0] addr);
    word_idx = addr[spec_pkg::ADDR_LSB +: 3];
  endfunction

  // Gate first, then mode strap, then broadcast pin
  function automatic spec_mode_type strap_mode(input spec_pkg::spec_strap_type s);
    if (!s.output_gate) begin
      strap_mode = MODE_OFF;
    end else if (s.control_mode_strap) begin
      strap_mode = MODE_REG;
    end else if (s.broadcast_select) begin
      strap_mode = MODE_BCAST;
    end else begin
      strap_mode = MODE_SINGLE;
    end
  endfunction

  // ******************************************************
  // Avalon-MM slave: one wait cycle per access
  // ******************************************************

  // Waitrequest drops in the cycle after the request appears
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign reg_idx           = word_idx(avs_address_i);
  assign reg_hit           = reg_idx <= spec_pkg::PINS_IDX;
  assign wr_done           = avs_write_i & ack_q;
  assign rd_done           = avs_read_i & ack_q;
  assign avs_readdata_o    = rdata_q;

  // Acknowledge toggles so back-to-back requests each wait once
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (reg_idx)
      spec_pkg::CFG_IDX:   rd_value = {24'h00_0000, cfg_q};
      spec_pkg::RXSET_IDX: rd_value = {24'h00_0000, rxset_q};
      spec_pkg::STAT_IDX:  rd_value = {29'h0000_0000, stat_q};
      spec_pkg::MASK_IDX:  rd_value = {29'h0000_0000, mask_q};
      spec_pkg::PINS_IDX:  rd_value = {22'h00_0000, strap_i, hotplug_port_b_i, hotplug_port_a_i};
      default:             rd_value = 32'h0000_0000;
    endcase
  end

  // Read data captured as waitrequest falls
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q) begin
      rdata_q <= rd_value;
    end
  end

  // Configuration register, port 1/port 2 enables and normal bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= spec_pkg::CFG_RST;
    end else if (wr_done && reg_hit && reg_idx == spec_pkg::CFG_IDX && avs_byteenable_i[0]) begin
      cfg_q <= avs_writedata_i[7:0];
    end
  end

  // Receiver settings register, squelch and termination bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rxset_q <= spec_pkg::RXSET_RST;
    end else if (wr_done && reg_hit && reg_idx == spec_pkg::RXSET_IDX && avs_byteenable_i[0]) begin
      rxset_q <= avs_writedata_i[7:0];
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_q <= spec_pkg::MASK_RST;
    end else if (wr_done && reg_hit && reg_idx == spec_pkg::MASK_IDX && avs_byteenable_i[0]) begin
      mask_q <= avs_writedata_i[spec_pkg::EV_NUM-1:0];
    end
  end

  // ******************************************************
  // Interrupt status
  // ******************************************************

  // Event detection against last cycle's decision
  assign events[spec_pkg::EV_SQ_ENTER] = (sq_state == spec_pkg::SQ_MUTE) & (sq_prev_q == spec_pkg::SQ_RUN);
  assign events[spec_pkg::EV_SQ_LEAVE] = (sq_state == spec_pkg::SQ_RUN) & (sq_prev_q == spec_pkg::SQ_MUTE);
  assign events[spec_pkg::EV_HP_CHG]   = hp_out ^ hp_out_prev_q;

  // History for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sq_prev_q     <= spec_pkg::SQ_RUN;
      hp_out_prev_q <= 1'b0;
    end else begin
      sq_prev_q     <= sq_state;
      hp_out_prev_q <= hp_out;
    end
  end

  // Read clears only the bits it returned, so an event landing mid-read survives
  // A same-cycle event still sets; set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stat_q <= '0;
    end else if (rd_done && reg_idx == spec_pkg::STAT_IDX) begin
      stat_q <= (stat_q & ~rdata_q[spec_pkg::EV_NUM-1:0]) | events;
    end else begin
      stat_q <= stat_q | events;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ******************************************************
  // Clock-detect filter
  // ******************************************************

  // Flag flips only after the raw level holds for the full window
  // Costs the same latency on squelch entry and exit alike
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      det_q      <= 1'b0;
      filt_cnt_q <= '0;
    end else if (link_clk_level_i == det_q) begin
      filt_cnt_q <= '0;
    end else if (filt_cnt_q == spec_pkg::FILT_W'(spec_pkg::FILT_CYCLES - 1)) begin
      det_q      <= link_clk_level_i;
      filt_cnt_q <= '0;
    end else begin
      filt_cnt_q <= filt_cnt_q + 1'b1;
    end
  end

  // ******************************************************
  // Port decision, purely combinational
  // ******************************************************

  // Mode and squelch qualifiers
  assign gate       = strap_i.output_gate;
  assign reg_mode   = strap_i.control_mode_strap;
  assign sq_enabled = ~rxset_q[spec_pkg::RX_SQ_OFF];
  assign mode       = strap_mode(strap_i);

  // Squelch follows filtered detect; bit 1 set leaves data undriven-free
  assign sq_state = (gate && sq_enabled && !det_q) ? spec_pkg::SQ_MUTE
                                                   : spec_pkg::SQ_RUN;

  // Port selection by mode; standby bit only acts in register mode
  always_comb begin
    sel_a = 1'b0;
    sel_b = 1'b0;
    unique case (mode)
      MODE_OFF: begin
        sel_a = 1'b0;
        sel_b = 1'b0;
      end
      MODE_REG: begin
        sel_a = cfg_q[spec_pkg::CFG_PORT_A] & cfg_q[spec_pkg::CFG_NORMAL];
        sel_b = cfg_q[spec_pkg::CFG_PORT_B] & cfg_q[spec_pkg::CFG_NORMAL];
      end
      MODE_BCAST: begin
        sel_a = 1'b1;
        sel_b = 1'b1;
      end
      MODE_SINGLE: begin
        sel_a = ~strap_i.port_selector;
        sel_b = strap_i.port_selector;
      end
    endcase
  end

  // Hot-plug toward the source
  // Standby bit ignored here, so the source still sees plugged sinks
  always_comb begin
    hp_out = 1'b0;
    unique case (mode)
      MODE_OFF: begin
        hp_out = 1'b0;
      end
      MODE_REG: begin
        hp_out = (hotplug_port_a_i & cfg_q[spec_pkg::CFG_PORT_A]) |
                 (hotplug_port_b_i & cfg_q[spec_pkg::CFG_PORT_B]);
      end
      MODE_BCAST: begin
        hp_out = hotplug_port_a_i | hotplug_port_b_i;
      end
      MODE_SINGLE: begin
        hp_out = strap_i.port_selector ? hotplug_port_b_i : hotplug_port_a_i;
      end
    endcase
  end

  assign hotplug_to_source_o = hp_out;

  // Same gating for both ports, so one loop serves them
  assign sel_vec = {sel_b, sel_a};
  assign hp_vec  = {hotplug_port_b_i, hotplug_port_a_i};
  for (genvar g = 0; g < 2; g++) begin : g_port
    // Enabled only while selected, plugged and not squelched
    assign en_vec[g] = sel_vec[g] & hp_vec[g] & (sq_state == spec_pkg::SQ_RUN);
  end

  // Port outputs; squelch mutes to high impedance
  assign port_a_o.enable  = en_vec[0];
  assign port_b_o.enable  = en_vec[1];
  assign port_a_o.drv_hiz = ~en_vec[0];
  assign port_b_o.drv_hiz = ~en_vec[1];
  assign squelched_o      = sq_state == spec_pkg::SQ_MUTE;

  // Receiver and terminations
  assign rx_on_o             = gate;
  assign input_term_res_en_o = gate & (sq_enabled | ~rxset_q[spec_pkg::RX_TERM_OFF]);
  assign src_term_en_o       = gate & rout_select_i;
  assign port_status_o       = cfg_q[spec_pkg::CFG_PORT_A];

  // ******************************************************
  // Shared strap pins
  // ******************************************************

  // Address in register mode, swing and pre-emphasis in pin mode
  // No register drives swing or pre-emphasis, so register mode holds them at zero
  assign bus_addr_o   = reg_mode ? {strap_i.preemph_code_hi, strap_i.preemph_code_lo,
                                    strap_i.swing_code_hi, strap_i.swing_code_lo} : 4'h0;
  assign swing_code_o = reg_mode ? 2'h0 : {strap_i.swing_code_hi, strap_i.swing_code_lo};
  assign preemph_o    = reg_mode ? spec_pkg::EMPH_0DB0
                                 : spec_pkg::spec_emph_type'({strap_i.preemph_code_hi,
                                                              strap_i.preemph_code_lo});

endmodule // spec_ctrl

// file: verif/spec_ctrl_assertions.sv
// Concurrent checks on the ports of the splitter control block
`timescale 1ns/10ps
module spec_ctrl_assertions (
  input wire logic                     clk_i,
  input wire logic                     srst_i,
  input wire logic                     avs_read_i,
  input wire logic                     avs_write_i,
  input wire logic                     avs_waitrequest_o,
  input wire spec_pkg::spec_strap_type strap_i,
  input wire logic                     hotplug_port_a_i,
  input wire logic                     hotplug_port_b_i,
  input wire logic                     link_clk_level_i,
  input wire logic                     rout_select_i,
  input wire spec_pkg::spec_port_type  port_a_o,
  input wire spec_pkg::spec_port_type  port_b_o,
  input wire logic                     hotplug_to_source_o,
  input wire logic                     rx_on_o,
  input wire logic                     input_term_res_en_o,
  input wire logic                     src_term_en_o,
  input wire spec_pkg::spec_emph_type  preemph_o,
  input wire logic [3:0]               bus_addr_o,
  input wire logic                     squelched_o
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic       pin_on;
  logic [4:0] hi_cnt_q;
  // Pin control mode with the gate open
  assign pin_on = strap_i.output_gate & ~strap_i.control_mode_strap;
  // Run length of clock present, saturates so it never wraps
  always_ff @(posedge clk_i) begin
    if (srst_i || !link_clk_level_i) begin
      hi_cnt_q <= 5'h00;
    end else if (hi_cnt_q != 5'h1f) begin
      hi_cnt_q <= hi_cnt_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ****************************************
  // Assertions
  // ****************************************
  a_gate_off: assert property (
    !strap_i.output_gate |-> !(port_a_o.enable || port_b_o.enable || hotplug_to_source_o || rx_on_o
    || src_term_en_o || input_term_res_en_o)) else $error("outputs active with gate low");
  a_both_ports: assert property (
    pin_on && strap_i.broadcast_select && !squelched_o |-> port_a_o.enable == hotplug_port_a_i
    && port_b_o.enable == hotplug_port_b_i && hotplug_to_source_o == (hotplug_port_a_i || hotplug_port_b_i))
    else $error("broadcast enables wrong");
  a_one_port: assert property (
    pin_on && !strap_i.broadcast_select && !squelched_o |-> port_a_o.enable == (!strap_i.port_selector
    && hotplug_port_a_i) && port_b_o.enable == (strap_i.port_selector && hotplug_port_b_i))
    else $error("single port enable wrong");
  a_hp_single: assert property (
    pin_on && !strap_i.broadcast_select |-> hotplug_to_source_o == (strap_i.port_selector ? hotplug_port_b_i
    : hotplug_port_a_i)) else $error("hot-plug output wrong");
  a_emph_decode: assert property (
    !strap_i.control_mode_strap |-> preemph_o == {strap_i.preemph_code_hi, strap_i.preemph_code_lo})
    else $error("pre-emphasis code wrong");
  a_bus_addr: assert property (
    strap_i.control_mode_strap |-> bus_addr_o == strap_i[3:0]) else $error("address bits wrong");
  a_src_term: assert property (
    src_term_en_o == (strap_i.output_gate && rout_select_i)) else $error("source termination wrong");
  a_sq_mute: assert property (
    squelched_o |-> !port_a_o.enable && !port_b_o.enable && port_a_o.drv_hiz && port_b_o.drv_hiz
    && input_term_res_en_o) else $error("squelch outputs wrong");
  a_sq_leave: assert property (
    hi_cnt_q >= 5'd20 |-> !squelched_o) else $error("squelch kept with clock present");
  a_glitch_hold: assert property (
    squelched_o && $rose(link_clk_level_i) && !avs_write_i |=> squelched_o || !strap_i.output_gate)
    else $error("squelch left on a glitch");
  a_wait_once: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
endmodule // spec_ctrl_assertions

// file: verif/spec_sink_model.sv
// Behavioural model of the link source clock and the two display sinks
`timescale 1ns/10ps
module spec_sink_model (
  input  wire logic clk_i,
  input  wire logic plug_a_i,
  input  wire logic plug_b_i,
  input  wire logic clk_run_i,
  output logic      hotplug_port_a_o = 1'b0,
  output logic      hotplug_port_b_o = 1'b0,
  output logic      link_clk_level_o = 1'b0
);
  // Sinks and detector settle a cycle late, never in the same step
  always @(posedge clk_i) begin
    hotplug_port_a_o <= plug_a_i;
    hotplug_port_b_o <= plug_b_i;
    link_clk_level_o <= clk_run_i;
  end
endmodule // spec_sink_model

// file: verif/tb_splitter_port_enable_control.sv
// Self-checking bench for the splitter control block
`timescale 1ns/10ps
module tb_splitter_port_enable_control;
  logic clk_i = 1'b0, srst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, rout_select_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d;
  logic [3:0]  avs_byteenable_i = 4'hf, bus_addr_o;
  logic [1:0]  swing_code_o;
  logic [7:0]  cfg = 8'hff;
  logic pa = 1'b0, pb = 1'b0, run = 1'b0, avs_waitrequest_o, irq_o, hotplug_port_a_i, hotplug_port_b_i;
  logic link_clk_level_i, hotplug_to_source_o, port_status_o, rx_on_o, input_term_res_en_o, src_term_en_o;
  logic squelched_o;
  spec_pkg::spec_strap_type strap_i = 8'h00;
  spec_pkg::spec_port_type  port_a_o, port_b_o;
  spec_pkg::spec_emph_type  preemph_o;
  int miscompares = 0;
  int comparisons = 0;
  // Free-running 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  spec_ctrl uut (.clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .strap_i, .hotplug_port_a_i,
    .hotplug_port_b_i, .link_clk_level_i, .rout_select_i, .port_a_o, .port_b_o, .hotplug_to_source_o,
    .port_status_o, .rx_on_o, .input_term_res_en_o, .src_term_en_o, .preemph_o, .swing_code_o,
    .bus_addr_o, .squelched_o);
  spec_sink_model u_sink (.clk_i(clk_i), .plug_a_i(pa), .plug_b_i(pb), .clk_run_i(run),
    .hotplug_port_a_o(hotplug_port_a_i), .hotplug_port_b_o(hotplug_port_b_i), .link_clk_level_o(link_clk_level_i));
  // ****************************************
  // Bus cycle, compares and expectations
  // ****************************************
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v, input logic [3:0] e,
                     output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, v};
    avs_byteenable_i <= e;
    avs_read_i <= !w;
    avs_write_i <= w;
    // Waitrequest is read at the rising edge, before that edge's updates land
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: read %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_out(input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: outputs %h expected %h", $time, g, x);
    end
  endtask
  // Port outputs with squelch off: hot-plug, enables, status, receiver on, source termination, codes
  function automatic logic [15:0] exp_out(input spec_pkg::spec_strap_type s, input logic ha, input logic hb,
                                          input logic r, input logic [7:0] c);
    logic ea, eb, h;
    ea = 1'b0;
    eb = 1'b0;
    h = 1'b0;
    if (s.output_gate && s.control_mode_strap) begin
      ea = c[7] & c[5] & ha;
      eb = c[7] & c[4] & hb;
      h = (c[5] & ha) | (c[4] & hb);
    end else if (s.output_gate && s.broadcast_select) begin
      ea = ha;
      eb = hb;
      h = ha | hb;
    end else if (s.output_gate) begin
      ea = ~s.port_selector & ha;
      eb = s.port_selector & hb;
      h = s.port_selector ? hb : ha;
    end
    return {h, ea, eb, ~ea, ~eb, c[5], s.output_gate, s.output_gate & r,
            s.control_mode_strap ? {4'h0, s[3:0]} : {s[3:0], 4'h0}};
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog at 10000 cycles, well beyond the few hundred cycles the run needs
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    d = $urandom(74438);
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00, 4'hf, d);
      chk_reg(d, (i == 0) ? 32'hff : 32'h0);
    end
    // Writes that must be dropped: no low byte lane, unmapped word
    bus(1'b1, 5'h00, 8'h00, 4'he, d);
    bus(1'b1, 5'h14, 8'hff, 4'hf, d);
    bus(1'b0, 5'h00, 8'h00, 4'hf, d);
    chk_reg(d, 32'hff);
    bus(1'b1, 5'h04, 8'h02, 4'hf, d);
    for (int i = 0; i < 48; i++) begin
      if (i % 4 == 3) begin
        cfg = 8'($urandom);
        bus(1'b1, 5'h00, cfg, 4'hf, d);
      end
      @(posedge clk_i);
      strap_i <= 8'($urandom);
      rout_select_i <= 1'($urandom);
      pa <= 1'($urandom);
      pb <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk_out({hotplug_to_source_o, port_a_o.enable, port_b_o.enable, port_a_o.drv_hiz, port_b_o.drv_hiz,
        port_status_o, rx_on_o, src_term_en_o, preemph_o, swing_code_o, bus_addr_o},
        exp_out(strap_i, pa, pb, rout_select_i, cfg));
    end
    bus(1'b0, 5'h10, 8'h00, 4'hf, d);
    chk_reg(d, {22'h0, strap_i, pb, pa});
    // Squelch: enter with no clock, ride out a glitch, leave on steady clock
    @(posedge clk_i);
    strap_i <= 8'ha0;
    pa <= 1'b1;
    pb <= 1'b1;
    bus(1'b1, 5'h04, 8'h00, 4'hf, d);
    repeat (25) @(posedge clk_i);
    @(negedge clk_i);
    chk_out({12'h0, squelched_o, input_term_res_en_o, port_a_o.enable, port_b_o.enable}, 16'h000c);
    bus(1'b0, 5'h08, 8'h00, 4'hf, d);
    chk_reg(d & 32'h1, 32'h1);
    bus(1'b1, 5'h0c, 8'h02, 4'hf, d);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (5) @(posedge clk_i);
    run <= 1'b0;
    repeat (25) @(posedge clk_i);
    @(negedge clk_i);
    chk_out({14'h0, squelched_o, irq_o}, 16'h0002);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (25) @(posedge clk_i);
    @(negedge clk_i);
    chk_out({12'h0, squelched_o, port_a_o.enable, port_b_o.enable, irq_o}, 16'h0007);
    bus(1'b0, 5'h08, 8'h00, 4'hf, d);
    chk_reg(d & 32'h2, 32'h2);
    @(negedge clk_i);
    chk_out({15'h0, irq_o}, 16'h0000);
    give_verdict();
  end
endmodule // tb_splitter_port_enable_control

bind spec_ctrl spec_ctrl_assertions u_chk (.clk_i, .srst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .strap_i, .hotplug_port_a_i, .hotplug_port_b_i, .link_clk_level_i, .rout_select_i, .port_a_o, .port_b_o,
  .hotplug_to_source_o, .rx_on_o, .input_term_res_en_o, .src_term_en_o, .preemph_o, .bus_addr_o, .squelched_o);
